/* rtl/signaling_consts.svh */
// Constants for the thread and host-core signaling block
`ifndef SIGNALING_CONSTS_SVH
`define SIGNALING_CONSTS_SVH

// Thread population
`define THREAD_COUNT      24
`define THREAD_W          5
`define ENGINE_COUNT      6
`define CTX_PER_ENGINE    4
`define REC_QUEUE_DEPTH   2'h2

// Register byte offsets
`define ADDR_W            8
`define OFS_INT_FLAGS     8'h00
`define OFS_INT_SELECT    8'h04
`define OFS_THREAD_SIGNAL 8'h08
`define OFS_INPUT_STATES  8'h0c
`define OFS_SIGNAL_EVENTS 8'h10

// Field positions
`define SEL_FIQ_BIT       0
`define INS_REC_AVAIL_BIT 0
`define INS_PUSH_PROT_BIT 1
`define INS_SEL_REC_AVAIL 1'b0
`define INS_SEL_PUSH_PROT 1'b1

// Reset values
`define INT_FLAGS_RST     24'h000000
`define INT_SELECT_RST    1'b0
`define EVENTS_RST        4'h0

// Bus responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

/* rtl/signaling_pkg.sv */
// Types for the thread and host-core signaling block
package signaling_pkg;

    // Register-bus slave state
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_held;
        logic [7:0]  awaddr;
        logic        w_held;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        ar_held;
        logic [7:0]  araddr;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_state_s;

    // Pending inter-thread events of one engine
    typedef struct packed {
        logic [3:0] pending;
    } bank_state_s;

    // Top-level state
    typedef struct packed {
        logic [23:0] flags;
        logic        fiq_sel;
        logic        fiq;
        logic        irq;
        logic        rec_avail;
        logic        push_protect;
        logic        inp_taken;
        logic        nosig_taken;
    } core_state_s;

endpackage

/* rtl/engine_event_bank.sv */
// Inter-thread event bits of the four contexts of one engine
`timescale 1ns/10ps
`default_nettype none
`include "signaling_consts.svh"

module engine_event_bank #(
    parameter logic [2:0] ENGINE = 3'h0
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       host_sig_valid,
    input  wire logic [4:0] host_sig_thread,
    input  wire logic       eng_sig_valid,
    input  wire logic [4:0] eng_sig_thread,
    input  wire logic       clr_valid,
    input  wire logic [4:0] clr_thread,
    output logic      [3:0] pending
);

    signaling_pkg::bank_state_s s_r;
    signaling_pkg::bank_state_s s_nxt;

    // One-hot context select when the broadcast names one of our contexts
    function automatic logic [3:0] ctx_onehot(input logic v, input logic [4:0] t);
        logic [3:0] oh;
        oh = 4'h0;
        if (v && t < 5'(`THREAD_COUNT) && t[4:2] == ENGINE) begin
            oh[t[1:0]] = 1'b1;
        end
        return oh;
    endfunction

    // Set beats clear so an event landing on the consume cycle survives
    always_comb begin
        s_nxt = s_r;
        s_nxt.pending = (s_r.pending & ~ctx_onehot(clr_valid, clr_thread))
                      | ctx_onehot(host_sig_valid, host_sig_thread)
                      | ctx_onehot(eng_sig_valid, eng_sig_thread);
    end

    // Unbuffered: a repeat on a set bit merges into it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r.pending <= `EVENTS_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pending = s_r.pending;

endmodule // engine_event_bank

`default_nettype wire

/* rtl/axil_reg_slave.sv */
// AXI4-Lite slave front end with one write and one read in flight
`timescale 1ns/10ps
`default_nettype none
`include "signaling_consts.svh"

module axil_reg_slave (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axil_awaddr,
    input  wire logic        s_axil_awvalid,
    output logic             s_axil_awready,
    input  wire logic [31:0] s_axil_wdata,
    input  wire logic [3:0]  s_axil_wstrb,
    input  wire logic        s_axil_wvalid,
    output logic             s_axil_wready,
    output logic [1:0]       s_axil_bresp,
    output logic             s_axil_bvalid,
    input  wire logic        s_axil_bready,
    input  wire logic [7:0]  s_axil_araddr,
    input  wire logic        s_axil_arvalid,
    output logic             s_axil_arready,
    output logic [31:0]      s_axil_rdata,
    output logic [1:0]       s_axil_rresp,
    output logic             s_axil_rvalid,
    input  wire logic        s_axil_rready,
    output logic             wr_en,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic [1:0]  wr_resp,
    output logic             rd_en,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic [1:0]  rd_resp
);

    signaling_pkg::axil_state_s s_r;
    signaling_pkg::axil_state_s s_nxt;

    // Write strobe fires once both halves of a write are held, read strobe once the address is held
    assign wr_en   = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    assign wr_addr = s_r.awaddr;
    assign wr_data = s_r.wdata;
    assign wr_strb = s_r.wstrb;
    assign rd_en   = s_r.ar_held && !s_r.rvalid;
    assign rd_addr = s_r.araddr;

    // Channel handshakes; address and data may come in either order
    always_comb begin
        s_nxt = s_r;
        if (s_axil_awvalid && s_r.awready) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.awaddr  = s_axil_awaddr;
        end
        if (s_axil_wvalid && s_r.wready) begin
            s_nxt.w_held = 1'b1;
            s_nxt.wdata  = s_axil_wdata;
            s_nxt.wstrb  = s_axil_wstrb;
        end
        if (wr_en) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = wr_resp;
        end else if (s_r.bvalid && s_axil_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_axil_arvalid && s_r.arready) begin
            s_nxt.ar_held = 1'b1;
            s_nxt.araddr  = s_axil_araddr;
        end
        if (rd_en) begin
            s_nxt.ar_held = 1'b0;
            s_nxt.rvalid  = 1'b1;
            s_nxt.rdata   = rd_data;
            s_nxt.rresp   = rd_resp;
        end else if (s_r.rvalid && s_axil_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        // Readies stay low until the previous answer has been taken
        s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid && !wr_en;
        s_nxt.wready  = !s_nxt.w_held && !s_nxt.bvalid && !wr_en;
        s_nxt.arready = !s_nxt.ar_held && !s_nxt.rvalid && !rd_en;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axil_awready = s_r.awready;
    assign s_axil_wready  = s_r.wready;
    assign s_axil_bvalid  = s_r.bvalid;
    assign s_axil_bresp   = s_r.bresp;
    assign s_axil_arready = s_r.arready;
    assign s_axil_rvalid  = s_r.rvalid;
    assign s_axil_rdata   = s_r.rdata;
    assign s_axil_rresp   = s_r.rresp;

endmodule // axil_reg_slave

`default_nettype wire

/* rtl/thread_core_signaling.sv */
// Thread-to-host interrupts, inter-thread signals and engine input states
`timescale 1ns/10ps
`default_nettype none
`include "signaling_consts.svh"

module thread_core_signaling (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Register bus
    input  wire logic [7:0]  s_axil_awaddr,
    input  wire logic        s_axil_awvalid,
    output logic             s_axil_awready,
    input  wire logic [31:0] s_axil_wdata,
    input  wire logic [3:0]  s_axil_wstrb,
    input  wire logic        s_axil_wvalid,
    output logic             s_axil_wready,
    output logic [1:0]       s_axil_bresp,
    output logic             s_axil_bvalid,
    input  wire logic        s_axil_bready,
    input  wire logic [7:0]  s_axil_araddr,
    input  wire logic        s_axil_arvalid,
    output logic             s_axil_arready,
    output logic [31:0]      s_axil_rdata,
    output logic [1:0]       s_axil_rresp,
    output logic             s_axil_rvalid,
    input  wire logic        s_axil_rready,
    // Thread fast writes to the interrupt flags
    input  wire logic        fast_wr_valid,
    input  wire logic [4:0]  fast_wr_thread,
    input  wire logic [23:0] fast_wr_data,
    // Thread writes to the inter-thread signal register
    input  wire logic        thread_sig_valid,
    input  wire logic [4:0]  thread_sig_target,
    // Context arbiter consumes an event
    input  wire logic        event_clr_valid,
    input  wire logic [4:0]  event_clr_thread,
    // Input-state sources
    input  wire logic [1:0]  rec_req_count,
    input  wire logic        autopush_active,
    input  wire logic        push_writing_xfer,
    // Branch queries
    input  wire logic        branch_on_input_state,
    input  wire logic        branch_input_select,
    input  wire logic        branch_on_no_signal,
    input  wire logic [4:0]  branch_no_signal_thread,
    // Engine and host outputs
    output logic             rec_req_avail,
    output logic             push_protect,
    output logic             input_branch_taken,
    output logic             no_signal_branch_taken,
    output logic [23:0]      signal_wakeup,
    output logic             host_fiq,
    output logic             host_irq
);

    signaling_pkg::core_state_s s_r;
    signaling_pkg::core_state_s s_nxt;

    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [1:0]  wr_resp;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic [1:0]  rd_resp;
    logic [23:0] pending;
    logic        host_sig_valid;
    logic [4:0]  host_sig_thread;
    logic [23:0] fast_set;
    logic [23:0] host_clr;
    logic [31:0] lane_mask;

    // Byte-enable expansion for write strobes
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // Address decode shared by reads and writes
    function automatic logic addr_mapped(input logic [7:0] a);
        return a == `OFS_INT_FLAGS || a == `OFS_INT_SELECT || a == `OFS_THREAD_SIGNAL
            || a == `OFS_INPUT_STATES || a == `OFS_SIGNAL_EVENTS;
    endfunction

    axil_reg_slave u_bus (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .s_axil_awaddr  (s_axil_awaddr),
        .s_axil_awvalid (s_axil_awvalid),
        .s_axil_awready (s_axil_awready),
        .s_axil_wdata   (s_axil_wdata),
        .s_axil_wstrb   (s_axil_wstrb),
        .s_axil_wvalid  (s_axil_wvalid),
        .s_axil_wready  (s_axil_wready),
        .s_axil_bresp   (s_axil_bresp),
        .s_axil_bvalid  (s_axil_bvalid),
        .s_axil_bready  (s_axil_bready),
        .s_axil_araddr  (s_axil_araddr),
        .s_axil_arvalid (s_axil_arvalid),
        .s_axil_arready (s_axil_arready),
        .s_axil_rdata   (s_axil_rdata),
        .s_axil_rresp   (s_axil_rresp),
        .s_axil_rvalid  (s_axil_rvalid),
        .s_axil_rready  (s_axil_rready),
        .wr_en          (wr_en),
        .wr_addr        (wr_addr),
        .wr_data        (wr_data),
        .wr_strb        (wr_strb),
        .wr_resp        (wr_resp),
        .rd_en          (rd_en),
        .rd_addr        (rd_addr),
        .rd_data        (rd_data),
        .rd_resp        (rd_resp)
    );

    // Host write to the signal register becomes a broadcast beat
    assign lane_mask       = strb_mask(wr_strb);
    assign host_sig_valid  = wr_en && wr_addr == `OFS_THREAD_SIGNAL && wr_strb[0];
    assign host_sig_thread = wr_data[4:0];
    assign wr_resp         = addr_mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
    assign rd_resp         = addr_mapped(rd_addr) ? `RESP_OKAY : `RESP_SLVERR;

    // Host and thread signals go to all engines on separate lanes so neither is lost
    for (genvar e = 0; e < `ENGINE_COUNT; e++) begin : g_engine
        engine_event_bank #(
            .ENGINE (3'(e))
        ) u_bank (
            .aclk            (aclk),
            .aresetn         (aresetn),
            .host_sig_valid  (host_sig_valid),
            .host_sig_thread (host_sig_thread),
            .eng_sig_valid   (thread_sig_valid),
            .eng_sig_thread  (thread_sig_target),
            .clr_valid       (event_clr_valid),
            .clr_thread      (event_clr_thread),
            .pending         (pending[e*`CTX_PER_ENGINE +: `CTX_PER_ENGINE])
        );
    end

    // Event bits leave straight from the bank flops to wake the arbiter
    assign signal_wakeup = pending;

    // Read data mux; reserved bits read as zero
    always_comb begin
        rd_data = 32'h0;
        case (rd_addr)
            `OFS_INT_FLAGS:     rd_data[23:0] = s_r.flags;
            `OFS_INT_SELECT:    rd_data[`SEL_FIQ_BIT] = s_r.fiq_sel;
            `OFS_INPUT_STATES: begin
                rd_data[`INS_REC_AVAIL_BIT] = s_r.rec_avail;
                rd_data[`INS_PUSH_PROT_BIT] = s_r.push_protect;
            end
            `OFS_SIGNAL_EVENTS: rd_data[23:0] = pending;
            default:            rd_data = 32'h0;
        endcase
    end

    // Raw fast-write data is shifted; values other than 1 spill into neighbours
    assign fast_set = fast_wr_valid && fast_wr_thread < 5'(`THREAD_COUNT)
                    ? fast_wr_data << fast_wr_thread : 24'h0;

    // Write-one-to-clear on the flag register, honouring byte lanes
    assign host_clr = wr_en && wr_addr == `OFS_INT_FLAGS
                    ? wr_data[23:0] & lane_mask[23:0] : 24'h0;

    // Next state of flags, select, host lines and engine status
    always_comb begin
        s_nxt = s_r;
        // A thread setting its flag in the clearing cycle keeps it set
        s_nxt.flags = (s_r.flags & ~host_clr) | fast_set;
        if (wr_en && wr_addr == `OFS_INT_SELECT && wr_strb[0]) begin
            s_nxt.fiq_sel = wr_data[`SEL_FIQ_BIT];
        end
        // Host lines follow the registered flags one cycle later
        s_nxt.fiq = s_r.fiq_sel && |s_r.flags;
        s_nxt.irq = !s_r.fiq_sel && |s_r.flags;
        // Status lines sampled every cycle from the live sources
        s_nxt.rec_avail    = rec_req_count < `REC_QUEUE_DEPTH;
        s_nxt.push_protect = autopush_active && push_writing_xfer;
        // Branch answers use the states as they stand now
        if (branch_on_input_state) begin
            s_nxt.inp_taken = branch_input_select == `INS_SEL_PUSH_PROT
                            ? s_r.push_protect : s_r.rec_avail;
        end else begin
            s_nxt.inp_taken = 1'b0;
        end
        if (branch_on_no_signal && branch_no_signal_thread < 5'(`THREAD_COUNT)) begin
            s_nxt.nosig_taken = !pending[branch_no_signal_thread];
        end else begin
            s_nxt.nosig_taken = 1'b0;
        end
    end

    // Single state register of the top
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r.flags        <= `INT_FLAGS_RST;
            s_r.fiq_sel      <= `INT_SELECT_RST;
            s_r.fiq          <= 1'b0;
            s_r.irq          <= 1'b0;
            s_r.rec_avail    <= 1'b0;
            s_r.push_protect <= 1'b0;
            s_r.inp_taken    <= 1'b0;
            s_r.nosig_taken  <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign rec_req_avail          = s_r.rec_avail;
    assign push_protect           = s_r.push_protect;
    assign input_branch_taken     = s_r.inp_taken;
    assign no_signal_branch_taken = s_r.nosig_taken;
    assign host_fiq               = s_r.fiq;
    assign host_irq               = s_r.irq;

endmodule // thread_core_signaling

`default_nettype wire

/* testbench/signaling_chk.sv */
// Port assertions for the thread and host-core signaling block
`timescale 1ns/10ps
`default_nettype none

module signaling_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        fast_wr_valid,
    input wire logic [4:0]  fast_wr_thread,
    input wire logic [23:0] fast_wr_data,
    input wire logic        thread_sig_valid,
    input wire logic [4:0]  thread_sig_target,
    input wire logic [1:0]  rec_req_count,
    input wire logic        autopush_active,
    input wire logic        push_writing_xfer,
    input wire logic        branch_on_input_state,
    input wire logic        branch_input_select,
    input wire logic        branch_on_no_signal,
    input wire logic [4:0]  branch_no_signal_thread,
    input wire logic        rec_req_avail,
    input wire logic        push_protect,
    input wire logic        input_branch_taken,
    input wire logic        no_signal_branch_taken,
    input wire logic [23:0] signal_wakeup,
    input wire logic        host_fiq,
    input wire logic        host_irq
);
    // One clock domain, so clocking and reset are given once
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Guarded by the previous cycle so reset values never count
    property p_avail;
        $past(aresetn) |=> rec_req_avail == ($past(rec_req_count) < 2'h2);
    endproperty
    a_avail: assert property (p_avail) else $error("receive availability wrong");

    property p_push;
        $past(aresetn) |=> push_protect == $past(autopush_active && push_writing_xfer);
    endproperty
    a_push: assert property (p_push) else $error("push protect wrong");

    property p_inp;
        branch_on_input_state |=>
            input_branch_taken == $past(branch_input_select ? push_protect : rec_req_avail);
    endproperty
    a_inp: assert property (p_inp) else $error("input branch wrong");

    property p_excl;
        !(host_fiq && host_irq);
    endproperty
    a_excl: assert property (p_excl) else $error("both host lines high");

    // Host line is two registers behind the fast write
    property p_fast;
        fast_wr_valid && fast_wr_thread < 5'h18 && fast_wr_data == 24'h1
            |-> ##2 (host_fiq || host_irq);
    endproperty
    a_fast: assert property (p_fast) else $error("host line not raised");

    property p_sig;
        thread_sig_valid && thread_sig_target < 5'h18 |=>
            signal_wakeup[$past(thread_sig_target)];
    endproperty
    a_sig: assert property (p_sig) else $error("event bit not set");

    property p_nosig;
        branch_on_no_signal && branch_no_signal_thread < 5'h18 |=>
            no_signal_branch_taken == !$past(signal_wakeup[branch_no_signal_thread]);
    endproperty
    a_nosig: assert property (p_nosig) else $error("no-signal branch wrong");

    property p_reset;
        $rose(aresetn) |-> signal_wakeup == 24'h0 && !host_fiq && !host_irq;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs live after reset");

    c_fast: cover property (fast_wr_valid ##2 host_irq);
    c_sig: cover property (thread_sig_valid ##1 signal_wakeup != 24'h0);
    c_nosig: cover property (branch_on_no_signal ##1 no_signal_branch_taken);
endmodule // signaling_chk

bind thread_core_signaling signaling_chk u_chk (
    .aclk, .aresetn, .fast_wr_valid, .fast_wr_thread, .fast_wr_data,
    .thread_sig_valid, .thread_sig_target, .rec_req_count, .autopush_active,
    .push_writing_xfer, .branch_on_input_state, .branch_input_select,
    .branch_on_no_signal, .branch_no_signal_thread, .rec_req_avail, .push_protect,
    .input_branch_taken, .no_signal_branch_taken, .signal_wakeup, .host_fiq, .host_irq
);

`default_nettype wire

/* testbench/engine_thread_model.sv */
// Engine-thread model issuing fast writes and inter-thread signals
`timescale 1ns/10ps
`default_nettype none

module engine_thread_model (
    input  wire logic   aclk,
    output var logic        fast_wr_valid,
    output var logic [4:0]  fast_wr_thread,
    output var logic [23:0] fast_wr_data,
    output var logic        thread_sig_valid,
    output var logic [4:0]  thread_sig_target
);
    // Idle lanes carry the inverse of their last value, so no stale copy passes
    initial begin
        fast_wr_valid     = 1'b0;
        fast_wr_thread    = 5'h1f;
        fast_wr_data      = 24'hfffffe;
        thread_sig_valid  = 1'b0;
        thread_sig_target = 5'h1f;
    end

    // One fast write from the given thread
    task automatic raise_int(input logic [4:0] thr);
        @(posedge aclk);
        fast_wr_valid  <= 1'b1;
        fast_wr_thread <= thr;
        fast_wr_data   <= 24'h000001;
        @(posedge aclk);
        fast_wr_valid  <= 1'b0;
        fast_wr_thread <= ~thr;
        fast_wr_data   <= 24'hfffffe;
    endtask

    // n back-to-back signal writes naming one thread
    task automatic send_sig(input logic [4:0] thr, input int n);
        @(posedge aclk);
        thread_sig_valid  <= 1'b1;
        thread_sig_target <= thr;
        repeat (n) @(posedge aclk);
        thread_sig_valid  <= 1'b0;
        thread_sig_target <= ~thr;
    endtask
endmodule // engine_thread_model

`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the signaling block
`timescale 1ns/10ps
`default_nettype none
`include "signaling_consts.svh"

module tb;
    logic        aclk, aresetn;
    logic [7:0]  s_axil_awaddr, s_axil_araddr;
    logic [31:0] s_axil_wdata, s_axil_rdata;
    logic [3:0]  s_axil_wstrb;
    logic        s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready;
    logic        s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    logic [1:0]  s_axil_bresp, s_axil_rresp, rec_req_count;
    logic        fast_wr_valid, thread_sig_valid, event_clr_valid;
    logic [4:0]  fast_wr_thread, thread_sig_target, event_clr_thread, branch_no_signal_thread;
    logic [23:0] fast_wr_data, signal_wakeup;
    logic        autopush_active, push_writing_xfer, branch_on_input_state;
    logic        branch_input_select, branch_on_no_signal, rec_req_avail, push_protect;
    logic        input_branch_taken, no_signal_branch_taken, host_fiq, host_irq;
    int          bad_count, comparisons;

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    thread_core_signaling DUT (.*);
    engine_thread_model TM (.aclk, .fast_wr_valid, .fast_wr_thread, .fast_wr_data,
        .thread_sig_valid, .thread_sig_target);

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // Address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axil_awaddr  <= a;
        s_axil_awvalid <= 1'b1;
        s_axil_wdata   <= d;
        s_axil_wvalid  <= 1'b1;
        s_axil_bready  <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!s_axil_awready);
                s_axil_awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!s_axil_wready);
                s_axil_wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (!s_axil_bvalid);
        s_axil_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axil_bresp});
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] e);
        @(posedge aclk);
        s_axil_araddr  <= a;
        s_axil_arvalid <= 1'b1;
        s_axil_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axil_arready);
        s_axil_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axil_rvalid);
        s_axil_rready <= 1'b0;
        chk("rresp", {30'h0, er}, {30'h0, s_axil_rresp});
        chk("rdata", e, s_axil_rdata);
    endtask

    // Branch queries are one-cycle pulses answered in the next cycle
    task automatic nosig(input logic [4:0] t, input logic e);
        @(posedge aclk);
        branch_on_no_signal     <= 1'b1;
        branch_no_signal_thread <= t;
        @(posedge aclk);
        branch_on_no_signal <= 1'b0;
        @(posedge aclk);
        chk("nosig", {31'h0, e}, {31'h0, no_signal_branch_taken});
    endtask

    task automatic inp(input logic s, input logic e);
        @(posedge aclk);
        branch_on_input_state <= 1'b1;
        branch_input_select   <= s;
        @(posedge aclk);
        branch_on_input_state <= 1'b0;
        @(posedge aclk);
        chk("inp", {31'h0, e}, {31'h0, input_branch_taken});
    endtask

    task automatic clr(input logic [4:0] t);
        @(posedge aclk);
        event_clr_valid  <= 1'b1;
        event_clr_thread <= t;
        @(posedge aclk);
        event_clr_valid <= 1'b0;
    endtask

    task automatic s_flags();
        TM.raise_int(5'h0);
        TM.raise_int(5'h17);
        TM.raise_int(5'h18);
        repeat (2) @(posedge aclk);
        chk("irq", 32'h1, {31'h0, host_irq});
        chk("fiq", 32'h0, {31'h0, host_fiq});
        reg_rd(`OFS_INT_FLAGS, `RESP_OKAY, 32'h800001);
        axi_wr(`OFS_INT_SELECT, 32'h1, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("fiq", 32'h1, {31'h0, host_fiq});
        chk("irq", 32'h0, {31'h0, host_irq});
        axi_wr(`OFS_INT_FLAGS, 32'h1, `RESP_OKAY);
        reg_rd(`OFS_INT_FLAGS, `RESP_OKAY, 32'h800000);
    endtask

    task automatic s_signal();
        axi_wr(`OFS_THREAD_SIGNAL, 32'h5, `RESP_OKAY);
        axi_wr(`OFS_THREAD_SIGNAL, 32'h18, `RESP_OKAY);
        TM.send_sig(5'h17, 1);
        @(posedge aclk);
        chk("wakeup", 32'h800020, {8'h0, signal_wakeup});
        reg_rd(`OFS_SIGNAL_EVENTS, `RESP_OKAY, 32'h800020);
        nosig(5'h5, 1'b0);
        nosig(5'h6, 1'b1);
        TM.send_sig(5'h7, 2);
        clr(5'h7);
        clr(5'h5);
        @(posedge aclk);
        chk("wakeup", 32'h800000, {8'h0, signal_wakeup});
    endtask

    // Reset mid-run with a flag and an event still pending
    task automatic s_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("wakeup", 32'h0, {8'h0, signal_wakeup});
        chk("fiq", 32'h0, {31'h0, host_fiq});
        reg_rd(`OFS_INT_FLAGS, `RESP_OKAY, 32'h0);
        reg_rd(`OFS_INT_SELECT, `RESP_OKAY, 32'h0);
    endtask

    task automatic s_inputs();
        for (int c = 0; c < 3; c++) begin
            @(posedge aclk);
            rec_req_count <= c[1:0];
            repeat (2) @(posedge aclk);
            chk("avail", {31'h0, c < 2}, {31'h0, rec_req_avail});
            inp(1'b0, c < 2);
        end
        for (int p = 0; p < 4; p++) begin
            @(posedge aclk);
            autopush_active   <= p[0];
            push_writing_xfer <= p[1];
            repeat (2) @(posedge aclk);
            inp(1'b1, p == 3);
        end
        reg_rd(`OFS_INPUT_STATES, `RESP_OKAY, 32'h2);
        reg_rd(8'h14, `RESP_SLVERR, 32'h0);
        axi_wr(8'h14, 32'hffffffff, `RESP_SLVERR);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        print_verdict();
    end

    initial begin
        {aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready} = 4'h0;
        {s_axil_arvalid, s_axil_rready, event_clr_valid} = 3'h0;
        {s_axil_awaddr, s_axil_araddr, s_axil_wdata} = 48'h0;
        s_axil_wstrb = 4'hf;
        {rec_req_count, event_clr_thread, branch_no_signal_thread} = 12'h0;
        {autopush_active, push_writing_xfer, branch_on_input_state} = 3'h0;
        {branch_input_select, branch_on_no_signal} = 2'h0;
        bad_count   = 0;
        comparisons = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        s_flags();
        s_signal();
        s_reset();
        s_inputs();
        print_verdict();
    end
endmodule // tb

`default_nettype wire
